/* inc/flc_defines.svh */
// Register offsets, field positions, reset values and table locations of the foldback register bank.
`ifndef FLC_DEFINES_SVH
`define FLC_DEFINES_SVH

`define FLC_ADDR_W 8
`define FLC_DATA_W 16

`define FLC_OFF_CTRL 8'h27
`define FLC_OFF_PTR 8'h2B
`define FLC_OFF_DATA 8'h2C

`define FLC_CTRL_EN_BIT 0
`define FLC_CTRL_RUN_BIT 1
`define FLC_CTRL_ABORT_BIT 2
`define FLC_CTRL_RESET 3'h3

`define FLC_PTR_RESET 8'h00
`define FLC_WORD_RESET 16'h0000

`define FLC_LIN_BASE 8'h20
`define FLC_LIN_COUNT 3
`define FLC_LIN_X_LSB 1
`define FLC_LIN_X_W 10
`define FLC_LIN_Y_W 8

`define FLC_XFR_BASE 8'h26
`define FLC_XFR_COUNT 4
`define FLC_XFR_X_W 8
`define FLC_XFR_Y_W 10

`define FLC_PRS_LOC 8'h2E
`define FLC_PRS_LSB 7
`define FLC_PRS_W 5

`endif

/* inc/flc_pkg.sv */
// Types shared by the foldback register bank.
package flc_pkg;
    typedef logic [15:0] flc_word_t;
    typedef enum logic [1:0] {
        FLC_IDLE = 2'b00,
        FLC_RUN = 2'b01,
        FLC_ABORTED = 2'b11
    } flc_seq_state_t;
endpackage

/* hdl/flc_ctrl_word.sv */
// Sequencer control word holding the enable, run and abort bits.
`include "flc_defines.svh"
module flc_ctrl_word
    import flc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Write port.
    input wire logic wr_en,
    input wire logic [2:0] wr_bits,
    // Stored bits.
    output logic [2:0] ctrl_q
);
    logic [2:0] ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            ctrl_d = wr_bits; // [R1] [R2] [R3]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `FLC_CTRL_RESET; // [R1] [R2] [R3]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
endmodule

/* hdl/flc_param_mem.sv */
// Flip-flop parameter memory with one write port and one read index.
`include "flc_defines.svh"
module flc_param_mem
    import flc_pkg::*;
#(
    parameter int DEPTH = 256
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Write port.
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire flc_word_t wr_word,
    // Read port.
    input wire logic [7:0] rd_idx,
    output flc_word_t rd_word,
    // All stored words.
    output flc_word_t [DEPTH-1:0] words_q
);
    flc_word_t [DEPTH-1:0] words_d;

    always_comb begin
        words_d = words_q;
        if (wr_en && (32'(wr_idx) < DEPTH)) begin
            words_d[wr_idx] = wr_word; // [R6]
        end
    end

    always_comb begin
        rd_word = `FLC_WORD_RESET;
        if (32'(rd_idx) < DEPTH) begin
            rd_word = words_q[rd_idx]; // [R6]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            words_q <= '0; // [R14]
        end else begin
            words_q <= words_d;
        end
    end
endmodule

/* hdl/flc_regs.sv */
// Foldback control register bank with indirect parameter memory access.
//
// What this block does
// [R1] Control bit 0 enables the sequencer; resets to one.
// [R2] Control bit 1 runs the sequencer only while enabled; resets to one.
// [R3] Control bit 2 aborts the sequencer when one; resets to zero.
// [R4] Pointer register bits 7-0 select the next parameter memory location.
// [R5] Every data register read or write advances the pointer by one.
// [R6] Data register writes store at the pointer; reads return that word.
// [R7] Software reaches parameter memory only through pointer and data registers.
// [R8] Linearizer X points carry a 10-bit code in bits 10-1.
// [R9] Linearizer X points at 20h, 22h, 24h; Y points at 21h, 23h, 25h.
// [R10] Linearizer Y points carry an 8-bit temperature in bits 7-0.
// [R11] Transfer X points carry 8-bit temperatures at 26h, 28h, 2Ah, 2Ch.
// [R12] Transfer Y points carry 10-bit codes at 27h, 29h, 2Bh, 2Dh.
// [R13] Pulse rate select is bits 11-7 of location 2Eh.
// [R14] All parameter memory words read zero after reset until loaded.
// [R15] Software halts the sequencer with a zero control word before changes.
// [R16] Software resumes by writing 3 to the control word.
// [R17] The pointer wraps from its maximum value to zero.
`include "flc_defines.svh"
module flc_regs
    import flc_pkg::*;
#(
    parameter int DEPTH = 256
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register access port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire flc_word_t reg_wdata,
    output flc_word_t reg_rdata,
    output logic reg_rvalid,
    // Sequencer controls and state.
    output logic sequencer_enable,
    output logic sequencer_run,
    output logic sequencer_abort,
    output flc_seq_state_t sequencer_state,
    // Foldback profile.
    output logic [2:0][9:0] linearizer_x_point,
    output logic [2:0][7:0] linearizer_y_point,
    output logic [3:0][7:0] transfer_x_point,
    output logic [3:0][9:0] transfer_y_point,
    output logic [4:0] pulse_rate_select
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic ctrl_wr;
    logic ptr_wr;
    logic data_wr;
    logic data_rd;
    logic data_acc;
    logic [2:0] ctrl_q;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    flc_word_t mem_rd_word;
    flc_word_t [DEPTH-1:0] words_q;
    flc_word_t rdata_d;
    flc_word_t rdata_q;
    logic rvalid_d;
    logic rvalid_q;
    flc_seq_state_t state_d;
    flc_seq_state_t state_q;

    assign ctrl_wr = reg_wr && hit(reg_addr, `FLC_OFF_CTRL);
    assign ptr_wr = reg_wr && hit(reg_addr, `FLC_OFF_PTR);
    assign data_wr = reg_wr && hit(reg_addr, `FLC_OFF_DATA);
    assign data_rd = reg_rd && hit(reg_addr, `FLC_OFF_DATA);
    assign data_acc = data_wr || data_rd;

    flc_ctrl_word u_ctrl (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_en(ctrl_wr),
        .wr_bits(reg_wdata[2:0]),
        .ctrl_q(ctrl_q)
    );

    flc_param_mem #(
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_en(data_wr),
        .wr_idx(ptr_q),
        .wr_word(reg_wdata),
        .rd_idx(ptr_q),
        .rd_word(mem_rd_word),
        .words_q(words_q)
    );

    assign sequencer_enable = ctrl_q[`FLC_CTRL_EN_BIT]; // [R1]
    assign sequencer_run = ctrl_q[`FLC_CTRL_RUN_BIT] && ctrl_q[`FLC_CTRL_EN_BIT]; // [R2]
    assign sequencer_abort = ctrl_q[`FLC_CTRL_ABORT_BIT]; // [R3]

    // Pointer register.
    always_comb begin
        ptr_d = ptr_q;
        if (ptr_wr) begin
            ptr_d = reg_wdata[7:0]; // [R4]
        end else if (data_acc) begin
            ptr_d = ptr_q + 8'h01; // [R5] [R17]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= `FLC_PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // Read data path.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        if (reg_rd) begin
            if (hit(reg_addr, `FLC_OFF_CTRL)) begin
                rdata_d = {13'h0000, ctrl_q};
            end else if (hit(reg_addr, `FLC_OFF_PTR)) begin
                rdata_d = {8'h00, ptr_q}; // [R4]
            end else if (hit(reg_addr, `FLC_OFF_DATA)) begin
                rdata_d = mem_rd_word; // [R6]
            end else begin
                rdata_d = `FLC_WORD_RESET;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `FLC_WORD_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Sequencer state.
    always_comb begin
        state_d = state_q;
        case (state_q)
            FLC_IDLE: begin
                if (sequencer_abort) begin
                    state_d = FLC_ABORTED; // [R3]
                end else if (sequencer_run) begin
                    state_d = FLC_RUN; // [R2]
                end
            end
            FLC_RUN: begin
                if (sequencer_abort) begin
                    state_d = FLC_ABORTED; // [R3]
                end else if (!sequencer_run) begin
                    state_d = FLC_IDLE; // [R1] [R2]
                end
            end
            FLC_ABORTED: begin
                if (!sequencer_abort) begin
                    state_d = FLC_IDLE;
                end
            end
            default: begin
                state_d = FLC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= FLC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign sequencer_state = state_q;

    // Profile fields taken from the parameter memory.
    always_comb begin
        for (int i = 0; i < `FLC_LIN_COUNT; i++) begin
            linearizer_x_point[i] =
                words_q[`FLC_LIN_BASE + 2 * i][`FLC_LIN_X_LSB +: `FLC_LIN_X_W]; // [R8] [R9]
            linearizer_y_point[i] = words_q[`FLC_LIN_BASE + 2 * i + 1][`FLC_LIN_Y_W-1:0]; // [R9] [R10]
        end
        for (int i = 0; i < `FLC_XFR_COUNT; i++) begin
            transfer_x_point[i] = words_q[`FLC_XFR_BASE + 2 * i][`FLC_XFR_X_W-1:0]; // [R11]
            transfer_y_point[i] = words_q[`FLC_XFR_BASE + 2 * i + 1][`FLC_XFR_Y_W-1:0]; // [R12]
        end
        pulse_rate_select = words_q[`FLC_PRS_LOC][`FLC_PRS_LSB +: `FLC_PRS_W]; // [R13]
    end

    // Checks.
    property p_enable_follows_write;
        @(posedge clk_sys) disable iff (!rst_b)
        ctrl_wr |=> sequencer_enable == $past(reg_wdata[0]);
    endproperty
    a_enable_follows_write: assert property (p_enable_follows_write) // [R1]
        else $error("Enable bit does not follow the control write.");

    property p_run_needs_enable;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_q == FLC_RUN) |-> $past(sequencer_run && !sequencer_abort);
    endproperty
    a_run_needs_enable: assert property (p_run_needs_enable) // [R2]
        else $error("Sequencer runs without enable and run bits.");

    property p_abort_reaches_state;
        @(posedge clk_sys) disable iff (!rst_b)
        (ctrl_wr && reg_wdata[2]) |-> ##2 (state_q == FLC_ABORTED);
    endproperty
    a_abort_reaches_state: assert property (p_abort_reaches_state) // [R3]
        else $error("Abort write did not abort the sequencer.");

    property p_ptr_load;
        @(posedge clk_sys) disable iff (!rst_b)
        ptr_wr |=> ptr_q == $past(reg_wdata[7:0]);
    endproperty
    a_ptr_load: assert property (p_ptr_load) // [R4]
        else $error("Pointer did not take the written value.");

    property p_ptr_advance;
        @(posedge clk_sys) disable iff (!rst_b)
        data_acc |=> ptr_q == 8'($past(ptr_q) + 8'h01);
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) // [R5]
        else $error("Pointer did not advance after a data access.");

    property p_ptr_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (data_acc && ptr_q == 8'hFF) |=> ptr_q == 8'h00;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) // [R17]
        else $error("Pointer did not wrap to zero.");

    property p_data_store;
        @(posedge clk_sys) disable iff (!rst_b)
        (data_wr && 32'(ptr_q) < DEPTH) |=> words_q[$past(ptr_q)] == $past(reg_wdata);
    endproperty
    a_data_store: assert property (p_data_store) // [R6]
        else $error("Data write did not land at the pointer.");

    property p_data_fetch;
        @(posedge clk_sys) disable iff (!rst_b)
        data_rd |=> reg_rvalid && reg_rdata == $past(mem_rd_word);
    endproperty
    a_data_fetch: assert property (p_data_fetch) // [R6]
        else $error("Data read did not return the pointed word.");

    property p_lin_x_map;
        @(posedge clk_sys) disable iff (!rst_b)
        linearizer_x_point[1] == words_q[8'h22][10:1];
    endproperty
    a_lin_x_map: assert property (p_lin_x_map) // [R8]
        else $error("Linearizer X point field misplaced.");

    property p_lin_y_map;
        @(posedge clk_sys) disable iff (!rst_b)
        linearizer_y_point[2] == words_q[8'h25][7:0];
    endproperty
    a_lin_y_map: assert property (p_lin_y_map) // [R10]
        else $error("Linearizer Y point field misplaced.");

    property p_xfr_map;
        @(posedge clk_sys) disable iff (!rst_b)
        transfer_x_point[3] == words_q[8'h2C][7:0] && transfer_y_point[3] == words_q[8'h2D][9:0];
    endproperty
    a_xfr_map: assert property (p_xfr_map) // [R12]
        else $error("Transfer point fields misplaced.");

    property p_prs_map;
        @(posedge clk_sys) disable iff (!rst_b)
        pulse_rate_select == words_q[8'h2E][11:7];
    endproperty
    a_prs_map: assert property (p_prs_map) // [R13]
        else $error("Pulse rate select field misplaced.");

    property p_zero_after_reset;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> (words_q == '0 && ctrl_q == `FLC_CTRL_RESET);
    endproperty
    a_zero_after_reset: assert property (p_zero_after_reset) // [R14]
        else $error("State after reset is not the reset value.");

    c_run: cover property (@(posedge clk_sys) disable iff (!rst_b) state_q == FLC_IDLE ##1 state_q == FLC_RUN);
    c_abort: cover property (@(posedge clk_sys) disable iff (!rst_b) state_q == FLC_ABORTED);
    c_burst: cover property (@(posedge clk_sys) disable iff (!rst_b) data_wr ##1 data_wr);
    c_wrap: cover property (@(posedge clk_sys) disable iff (!rst_b) data_acc && ptr_q == 8'hFF);
endmodule

/* sim/flc_regs_bench.sv */
// Self-checking bench for the foldback register bank.
`include "flc_defines.svh"
module flc_regs_bench
    import flc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] loc;
        flc_word_t val;
    } flc_row_t;

    // One row per table location: location written, word written and read back.
    localparam flc_row_t ROWS [15] = '{
        '{8'h20, 16'h07FE}, '{8'h21, 16'h00A5}, '{8'h22, 16'h0402}, '{8'h23, 16'h0032},
        '{8'h24, 16'h0156}, '{8'h25, 16'h00C3}, '{8'h26, 16'h0014}, '{8'h27, 16'h0320},
        '{8'h28, 16'h0032}, '{8'h29, 16'h03FF}, '{8'h2A, 16'h004B}, '{8'h2B, 16'h02BC},
        '{8'h2C, 16'h0064}, '{8'h2D, 16'h0155}, '{8'h2E, 16'hF5A5}};

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    flc_word_t reg_wdata = 16'h0000;
    flc_word_t reg_rdata;
    logic reg_rvalid;
    logic sequencer_enable;
    logic sequencer_run;
    logic sequencer_abort;
    flc_seq_state_t sequencer_state;
    logic [2:0][9:0] linearizer_x_point;
    logic [2:0][7:0] linearizer_y_point;
    logic [3:0][7:0] transfer_x_point;
    logic [3:0][9:0] transfer_y_point;
    logic [4:0] pulse_rate_select;
    flc_word_t mem_m [256];
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    flc_regs #(.DEPTH(64)) u_flc_regs (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .sequencer_enable(sequencer_enable),
        .sequencer_run(sequencer_run),
        .sequencer_abort(sequencer_abort),
        .sequencer_state(sequencer_state),
        .linearizer_x_point(linearizer_x_point),
        .linearizer_y_point(linearizer_y_point),
        .transfer_x_point(transfer_x_point),
        .transfer_y_point(transfer_y_point),
        .pulse_rate_select(pulse_rate_select)
    );

    always #10 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input flc_word_t d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input string what, input logic [7:0] a, input flc_word_t exp);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("read valid", 16'h0001, {15'h0000, reg_rvalid});
        chk(what, exp, reg_rdata);
    endtask

    task automatic chk_ctrl(input logic en, input logic run, input logic ab);
        chk("enable", {15'h0000, en}, {15'h0000, sequencer_enable});
        chk("run", {15'h0000, run}, {15'h0000, sequencer_run});
        chk("abort", {15'h0000, ab}, {15'h0000, sequencer_abort});
    endtask

    task automatic chk_state(input flc_seq_state_t s);
        repeat (3) @(negedge clk_sys);
        chk("state", {14'h0000, s}, {14'h0000, sequencer_state});
    endtask

    task automatic chk_fields();
        for (int i = 0; i < 3; i++) begin
            chk("lin x", {6'h00, mem_m[32 + 2 * i][10:1]}, {6'h00, linearizer_x_point[i]});
            chk("lin y", {8'h00, mem_m[33 + 2 * i][7:0]}, {8'h00, linearizer_y_point[i]});
        end
        for (int i = 0; i < 4; i++) begin
            chk("xfr x", {8'h00, mem_m[38 + 2 * i][7:0]}, {8'h00, transfer_x_point[i]});
            chk("xfr y", {6'h00, mem_m[39 + 2 * i][9:0]}, {6'h00, transfer_y_point[i]});
        end
        chk("rate", {11'h000, mem_m[46][11:7]}, {11'h000, pulse_rate_select});
    endtask

    initial begin
        foreach (mem_m[i]) mem_m[i] = 16'h0000;
        repeat (20) @(negedge clk_sys);
        chk_ctrl(1'b1, 1'b1, 1'b0);
        rst_b = 1'b1;
        chk_state(FLC_RUN);
        rd("ctrl", `FLC_OFF_CTRL, 16'h0003);
        rd("ptr", `FLC_OFF_PTR, 16'h0000);
        chk_fields();
        rd("data", `FLC_OFF_DATA, 16'h0000);
        rd("ptr", `FLC_OFF_PTR, 16'h0001);
        wr(`FLC_OFF_CTRL, 16'h0000);
        chk_ctrl(1'b0, 1'b0, 1'b0);
        chk_state(FLC_IDLE);
        wr(`FLC_OFF_PTR, 16'h0020);
        foreach (ROWS[i]) begin
            wr(`FLC_OFF_DATA, ROWS[i].val);
            mem_m[ROWS[i].loc] = ROWS[i].val;
        end
        rd("ptr", `FLC_OFF_PTR, 16'h002F);
        chk_fields();
        wr(`FLC_OFF_PTR, 16'h0020);
        foreach (ROWS[i]) rd("table", `FLC_OFF_DATA, ROWS[i].val);
        wr(`FLC_OFF_PTR, 16'h0030);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = `FLC_OFF_DATA;
        reg_wdata = 16'hAAAA;
        @(negedge clk_sys);
        reg_wdata = 16'h5555;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        rd("ptr", `FLC_OFF_PTR, 16'h0032);
        wr(`FLC_OFF_PTR, 16'h0030);
        rd("b2b", `FLC_OFF_DATA, 16'hAAAA);
        rd("b2b", `FLC_OFF_DATA, 16'h5555);
        wr(`FLC_OFF_CTRL, 16'h0002);
        chk_ctrl(1'b0, 1'b0, 1'b0);
        wr(`FLC_OFF_CTRL, 16'h0007);
        chk_ctrl(1'b1, 1'b1, 1'b1);
        chk_state(FLC_ABORTED);
        wr(`FLC_OFF_CTRL, 16'h0003);
        chk_ctrl(1'b1, 1'b1, 1'b0);
        chk_state(FLC_RUN);
        rd("ctrl", `FLC_OFF_CTRL, 16'h0003);
        wr(`FLC_OFF_PTR, 16'h12FF);
        rd("ptr", `FLC_OFF_PTR, 16'h00FF);
        rd("high", `FLC_OFF_DATA, 16'h0000);
        rd("ptr", `FLC_OFF_PTR, 16'h0000);
        // A reset after an abort must restore the control word and clear the loaded table.
        wr(`FLC_OFF_CTRL, 16'h0004);
        chk_ctrl(1'b0, 1'b0, 1'b1);
        rd("ctrl", `FLC_OFF_CTRL, 16'h0004);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk_ctrl(1'b1, 1'b1, 1'b0);
        chk("reset rvalid", 16'h0000, {15'h0000, reg_rvalid});
        chk("reset rdata", 16'h0000, reg_rdata);
        foreach (mem_m[i]) mem_m[i] = 16'h0000;
        chk_fields();
        rst_b = 1'b1;
        chk_state(FLC_RUN);
        rd("reset ptr", `FLC_OFF_PTR, 16'h0000);
        wr(`FLC_OFF_PTR, 16'h0030);
        rd("reset data", `FLC_OFF_DATA, 16'h0000);
        wr(8'h30, 16'h0000);
        rd("ctrl", `FLC_OFF_CTRL, 16'h0003);
        rd("unmapped", 8'h30, 16'h0000);
        give_verdict();
    end
endmodule
